// >>> design/decode_slot_defs.svh
// Constants for the decode slot selector: queue geometry, slot count, opcode values.
// Assumes a single core clock at 250 MHz and a synchronous active-high reset.
`ifndef DECODE_SLOT_DEFS_SVH
`define DECODE_SLOT_DEFS_SVH

`define WINDOW_BYTES      16
`define QUEUE_BYTES       24
`define DECODE_SLOTS      3
`define ROM_DEPTH         64
`define ROM_ADDR_BITS     6
`define OPCODE_ALU_RM     8'h01
`define OPCODE_ALU_RR     8'h03
`define OPCODE_LOAD_OP    8'h8b
`define OPCODE_FLOAT_INT  8'hda
`define OPCODE_LEA16      8'h8d
`define OPCODE_STRING     8'ha5
`define LEN_FIELD_LSB     0
`define LEN_FIELD_BITS    4

`endif

// >>> design/decode_slot_pkg.sv
// Types shared by the decode slot selector and its microcode sequencer.
// Assumes decode_slot_defs.svh is included before use.
package decode_slot_pkg;

    typedef enum logic [1:0] {
        fast_decode_class        = 2'b00,
        microcoded_decode_class  = 2'b01
    } decode_class_type;

    typedef struct packed {
        logic [127:0] bytes;
        logic [31:0]  address;
    } fetch_window_type;

    typedef struct packed {
        logic             valid;
        decode_class_type dclass;
        logic [7:0]       opcode;
        logic [3:0]       length;
        logic [31:0]      address;
    } decoded_slot_type;

    typedef struct packed {
        logic        valid;
        logic [15:0] operation;
        logic        last;
    } internal_macro_operations_type;

endpackage : decode_slot_pkg

// >>> design/microcode_rom_sequencer.sv
// On-chip ROM sequencer: expands one microcoded instruction into internal operations.
// Assumes the caller starts it only while idle and holds fast decode while busy.
`timescale 1ns/10ps
`include "decode_slot_defs.svh"

module microcode_rom_sequencer (
    input  wire logic                                          core_clk,
    input  wire logic                                          reset,
    input  wire logic                                          start,
    input  wire logic [7:0]                                    opcode,
    output logic                                               busy,
    output decode_slot_pkg::internal_macro_operations_type     op_out
);
    import decode_slot_pkg::*;

    typedef enum logic [1:0] {
        seq_idle  = 2'b00,
        seq_issue = 2'b01
    } seq_state_type;

    seq_state_type               state;
    logic [`ROM_ADDR_BITS-1:0]   address;
    logic [15:0]                 rom [0:`ROM_DEPTH-1];

    // Entry word: [15] ends sequence, [14:8] op code, [7:0] source opcode tag
    initial begin
        for (int i = 0; i < `ROM_DEPTH; i++) begin
            rom[i] = {1'b0, 7'(i), 8'h00};
        end
        rom[1]  = {1'b1, 7'h01, 8'hda};
        rom[5]  = {1'b1, 7'h05, 8'h8d};
        rom[11] = {1'b1, 7'h0b, 8'ha5};
        rom[63] = {1'b1, 7'h3f, 8'h00};
    end

    // Entry point per opcode; the integer-operand float form gets a two-op sequence
    function automatic logic [`ROM_ADDR_BITS-1:0] entry_of(input logic [7:0] op);
        case (op)
            `OPCODE_FLOAT_INT: entry_of = 6'h00;
            `OPCODE_LEA16:     entry_of = 6'h04;
            `OPCODE_STRING:    entry_of = 6'h08;
            default:           entry_of = 6'h3e;
        endcase
    endfunction : entry_of

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state   <= seq_idle;
            address <= '0;
        end else begin
            case (state)
                seq_idle: begin
                    if (start) begin
                        state   <= seq_issue;
                        address <= entry_of(opcode);
                    end
                end
                seq_issue: begin
                    if (rom[address][15]) begin
                        state <= seq_idle;
                    end else begin
                        address <= address + 6'h01;
                    end
                end
                default: state <= seq_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            op_out <= '0;
        end else begin
            op_out.valid     <= (state == seq_issue);
            op_out.operation <= rom[address];
            op_out.last      <= (state == seq_issue) && rom[address][15];
        end
    end

    // Busy comes from state only: folding start in would loop back through the picker
    assign busy = (state != seq_idle);

endmodule : microcode_rom_sequencer

// >>> design/decode_slot_selector.sv
// Fetch, byte queue and decode-slot selection for variable-length instructions.
// Assumes the instruction cache answers a window request one or more cycles later.
`timescale 1ns/10ps
`include "decode_slot_defs.svh"

module decode_slot_selector #(
    parameter int WINDOW_BYTES = `WINDOW_BYTES,
    parameter int QUEUE_BYTES  = `QUEUE_BYTES
) (
    input  wire logic                                       core_clk,
    input  wire logic                                       reset,
    input  wire logic [31:0]                                start_address,
    input  wire logic                                       redirect,
    output logic                                            fetch_request,
    output logic [31:0]                                     fetch_address,
    input  wire logic                                       fetch_valid,
    input  wire decode_slot_pkg::fetch_window_type          fetch_window,
    output decode_slot_pkg::decoded_slot_type [2:0]         decode_slots,
    output decode_slot_pkg::internal_macro_operations_type  micro_op,
    output logic [4:0]                                      queue_level
);
    import decode_slot_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    logic [7:0]  queue [0:QUEUE_BYTES-1];
    logic [4:0]  count;
    logic [31:0] head_address;
    logic        pending;
    logic [4:0]  next_count;
    logic [5:0]  next_fill;
    logic [3:0]  skip;
    logic [4:0]  consumed;
    logic [1:0]  picked;
    logic        pick_micro;
    logic        micro_busy;
    decoded_slot_type [2:0] next_slots;

    // Length taken from the low opcode bits keeps the length decoder trivial
    function automatic logic [3:0] length_of(input logic [7:0] op);
        length_of = (op[`LEN_FIELD_BITS-1:`LEN_FIELD_LSB] == 4'h0) ? 4'h1
                    : op[`LEN_FIELD_BITS-1:`LEN_FIELD_LSB];
    endfunction : length_of

    // One class per opcode, never both
    function automatic decode_class_type class_of(input logic [7:0] op);
        case (op)
            `OPCODE_ALU_RM:    class_of = fast_decode_class;
            `OPCODE_ALU_RR:    class_of = fast_decode_class;
            `OPCODE_LOAD_OP:   class_of = fast_decode_class;
            `OPCODE_FLOAT_INT: class_of = microcoded_decode_class;
            `OPCODE_LEA16:     class_of = microcoded_decode_class;
            `OPCODE_STRING:    class_of = microcoded_decode_class;
            default:           class_of = fast_decode_class;
        endcase
    endfunction : class_of

    ////////////////////////////////////////////////////////////////////////////////
    // Selection: scan up to three complete instructions from the queue head

    always_comb begin
        logic [4:0]  offset;
        logic        stop;
        logic [7:0]  op;
        logic [3:0]  len;
        offset     = '0;
        stop       = 1'b0;
        op         = 8'h00;
        len        = 4'h0;
        picked     = '0;
        pick_micro = 1'b0;
        next_slots = '0;
        for (int s = 0; s < `DECODE_SLOTS; s++) begin
            op  = (offset < 5'(QUEUE_BYTES)) ? queue[offset] : 8'h00;
            len = length_of(op);
            // Six bits, so a long instruction near the tail cannot wrap under the count
            if (!stop && !micro_busy && !redirect
                && ((6'(offset) + 6'(len)) <= 6'(count))) begin
                if (class_of(op) == microcoded_decode_class) begin
                    if (s == 0) begin
                        pick_micro = 1'b1;
                        picked     = 2'd1;
                        offset     = 5'(offset + 5'(len));
                    end
                    stop = 1'b1;
                end else begin
                    next_slots[s].valid   = 1'b1;
                    next_slots[s].dclass  = fast_decode_class;
                    next_slots[s].opcode  = op;
                    next_slots[s].length  = len;
                    next_slots[s].address = head_address + 32'(offset);
                    picked = 2'(picked + 2'd1);
                    offset = 5'(offset + 5'(len));
                end
            end else begin
                stop = 1'b1;
            end
        end
        consumed = offset;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fetch: request a window only when sixteen bytes of room remain

    always_ff @(posedge core_clk) begin
        if (reset) begin
            fetch_request <= 1'b0;
            fetch_address <= '0;
            pending       <= 1'b0;
        end else if (redirect) begin
            fetch_request <= 1'b0;
            fetch_address <= {start_address[31:4], 4'h0};
            pending       <= 1'b0;
        end else begin
            fetch_request <= 1'b0;
            if (fetch_valid) begin
                pending       <= 1'b0;
                fetch_address <= 32'(fetch_address + 32'(WINDOW_BYTES));
            end else if (!pending && (next_count <= 5'(QUEUE_BYTES - WINDOW_BYTES))) begin
                fetch_request <= 1'b1;
                pending       <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte queue: shift out consumed bytes, append the arriving window

    assign next_count = 5'(count - consumed);
    // The first window after a redirect drops the bytes ahead of the target
    assign next_fill  = 6'(next_count) + 6'(WINDOW_BYTES) - 6'(skip);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count        <= '0;
            head_address <= '0;
            skip         <= 4'h0;
            for (int i = 0; i < QUEUE_BYTES; i++) begin
                queue[i] <= 8'h00;
            end
        end else if (redirect) begin
            count        <= '0;
            head_address <= start_address;
            skip         <= start_address[3:0];
        end else begin
            for (int i = 0; i < QUEUE_BYTES; i++) begin
                if (5'(i) < next_count) begin
                    queue[i] <= queue[5'(i) + consumed];
                end else if (fetch_valid && (6'(i) < next_fill)) begin
                    queue[i] <= fetch_window.bytes[8*(i - next_count + skip) +: 8];
                end
            end
            count        <= fetch_valid ? 5'(next_fill) : next_count;
            head_address <= head_address + 32'(consumed);
            if (fetch_valid) begin
                skip <= 4'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge core_clk) begin
        if (reset) begin
            decode_slots <= '0;
            queue_level  <= '0;
        end else begin
            decode_slots <= next_slots;
            queue_level  <= count;
        end
    end

    // Sequencer busy holds fast decode until the last operation leaves
    microcode_rom_sequencer u_sequencer (
        .core_clk (core_clk),
        .reset    (reset),
        .start    (pick_micro),
        .opcode   (queue[0]),
        .busy     (micro_busy),
        .op_out   (micro_op)
    );

endmodule : decode_slot_selector

// >>> tb/decode_slot_selector_monitor.sv
// Checker on the decode slot selector ports.
// Assumes the design package and header are compiled first.
`timescale 1ns/10ps
`include "decode_slot_defs.svh"
module decode_slot_selector_monitor #(
    parameter int WINDOW_BYTES = 16,
    parameter int QUEUE_BYTES  = 24
) (
    input wire logic                                          core_clk,
    input wire logic                                          reset,
    input wire logic [31:0]                                   start_address,
    input wire logic                                          redirect,
    input wire logic                                          fetch_request,
    input wire logic [31:0]                                   fetch_address,
    input wire logic                                          fetch_valid,
    input wire decode_slot_pkg::fetch_window_type             fetch_window,
    input wire decode_slot_pkg::decoded_slot_type [2:0]       decode_slots,
    input wire decode_slot_pkg::internal_macro_operations_type micro_op,
    input wire logic [4:0]                                    queue_level
);
    import decode_slot_pkg::*;
    decoded_slot_type s0, s1, s2;
    assign {s2, s1, s0} = decode_slots;
    function automatic logic is_fast(decoded_slot_type s);
        return s.valid && s.dclass == fast_decode_class;
    endfunction : is_fast
    function automatic logic bad_code(decoded_slot_type s);
        return is_fast(s) && s.opcode inside {`OPCODE_FLOAT_INT, `OPCODE_LEA16, `OPCODE_STRING};
    endfunction : bad_code
    ////////////////////////////////////////
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (reset);
    sequence s_req;
        fetch_request;
    endsequence
    sequence s_start;
        $rose(micro_op.valid);
    endsequence
    sequence s_two;
        !micro_op.last ##1 micro_op.valid;
    endsequence
    AST_ALIGN: assert property (s_req |-> fetch_address[3:0] == 4'h0)
        else $error("window request not aligned");
    AST_ONE_OUT: assert property (s_req |=> !fetch_request until fetch_valid)
        else $error("window requested while one is outstanding");
    AST_ROOM: assert property (s_req |=> queue_level <= 5'(QUEUE_BYTES - WINDOW_BYTES))
        else $error("window requested without room");
    AST_CAP: assert property (queue_level <= 5'(QUEUE_BYTES))
        else $error("byte queue over capacity");
    AST_ORDER: assert property (s1.valid |-> s0.valid && s1.address > s0.address)
        else $error("slots out of program order");
    AST_SLOT0: assert property (s1.valid == is_fast(s1) && s2.valid == is_fast(s2))
        else $error("microcoded pick outside slot zero");
    AST_SPLIT: assert property (micro_op.valid |-> !(is_fast(s0) || is_fast(s1) || is_fast(s2)))
        else $error("both classes decoded in one cycle");
    AST_CODE: assert property (!(bad_code(s0) || bad_code(s1) || bad_code(s2)))
        else $error("microcoded opcode in fast class");
    AST_SEVERAL: assert property (s_start |-> s_two)
        else $error("sequence shorter than two operations");
    AST_HOLD: assert property (micro_op.valid && !micro_op.last |=> micro_op.valid && !s0.valid)
        else $error("fast decode during a sequence");
endmodule : decode_slot_selector_monitor

bind decode_slot_selector decode_slot_selector_monitor #(
    .WINDOW_BYTES(WINDOW_BYTES),
    .QUEUE_BYTES(QUEUE_BYTES)
) i_monitor (
    .core_clk(core_clk),
    .reset(reset),
    .start_address(start_address),
    .redirect(redirect),
    .fetch_request(fetch_request),
    .fetch_address(fetch_address),
    .fetch_valid(fetch_valid),
    .fetch_window(fetch_window),
    .decode_slots(decode_slots),
    .micro_op(micro_op),
    .queue_level(queue_level)
);

// >>> tb/icache_model.sv
// Instruction cache model: answers each window request after a set delay.
// Assumes one outstanding request and a 64-byte image that wraps.
`timescale 1ns/10ps
module icache_model (
    input wire logic                         core_clk,
    input wire logic                         fetch_request,
    input wire logic [31:0]                  fetch_address,
    input wire logic [511:0]                 image,
    input wire logic [2:0]                   delay,
    output logic                             fetch_valid,
    output decode_slot_pkg::fetch_window_type fetch_window
);
    import decode_slot_pkg::*;
    logic [31:0] addr = '0;
    int          left = -1;
    initial fetch_valid = 1'b0;
    initial fetch_window = '0;
    // Window lines never hold between answers, so stale bytes cannot pass
    always @(posedge core_clk) begin
        fetch_valid <= 1'b0;
        fetch_window <= ~fetch_window;
        if (fetch_request) begin
            addr <= fetch_address;
            left <= delay;
        end else if (left == 0) begin
            fetch_valid <= 1'b1;
            fetch_window <= {image[addr[5:4]*128 +: 128], addr};
            left <= -1;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
endmodule : icache_model

// >>> tb/decode_slot_selector_tb.sv
// Self-checking bench for the decode slot selector.
// Assumes package, header, cache model and checker are compiled first.
`timescale 1ns/10ps
`include "decode_slot_defs.svh"
module decode_slot_selector_tb;
    import decode_slot_pkg::*;
    logic                          core_clk = 1'b0;
    logic                          reset = 1'b1;
    logic [31:0]                   start_address = '0;
    logic                          redirect = 1'b0;
    logic                          fetch_request;
    logic [31:0]                   fetch_address;
    logic                          fetch_valid;
    fetch_window_type              fetch_window;
    decoded_slot_type [2:0]        decode_slots;
    internal_macro_operations_type micro_op;
    logic [4:0]                    queue_level;
    logic [511:0]                  image = '0;
    logic [2:0]                    delay = '0;
    int                            bad_count = 0;
    int                            total_checks = 0;
    always #2 core_clk = ~core_clk;
    decode_slot_selector i_dut (.core_clk(core_clk), .reset(reset),
        .start_address(start_address), .redirect(redirect), .fetch_request(fetch_request),
        .fetch_address(fetch_address), .fetch_valid(fetch_valid), .fetch_window(fetch_window),
        .decode_slots(decode_slots), .micro_op(micro_op), .queue_level(queue_level));
    icache_model i_cache (.core_clk(core_clk), .fetch_request(fetch_request),
        .fetch_address(fetch_address), .image(image), .delay(delay),
        .fetch_valid(fetch_valid), .fetch_window(fetch_window));
    ////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out
    // Microcoded ones sit mid-stream; one straddles a window boundary
    task automatic load_program();
        logic [7:0] op[$] = '{8'h01, 8'h03, 8'h01, 8'h01, 8'hda, 8'h03, 8'h01, 8'ha5, 8'h01, 8'h8d};
        int a = 0;
        image = {64{8'h01}};
        foreach (op[i]) begin
            image[a*8 +: 8] = op[i];
            a += (op[i][3:0] == 4'h0) ? 1 : op[i][3:0];
        end
    endtask : load_program
    // Reset, redirect to from, then follow the stream for a fixed span
    task automatic t_stream(input logic [2:0] d, input logic [31:0] from);
        int exp[$];
        logic [31:0] got[$];
        logic [31:0] first_req = 32'hffffffff;
        int a = from;
        int ops = 0, first_len = 0, lasts = 0, most = 0, micros = 0, n;
        logic [7:0] op;
        while (a < 64) begin
            op = image[a*8 +: 8];
            if (op inside {`OPCODE_FLOAT_INT, `OPCODE_LEA16, `OPCODE_STRING}) micros++;
            else exp.push_back(a);
            a += (op[3:0] == 4'h0) ? 1 : op[3:0];
        end
        delay = d;
        reset = 1'b1;
        repeat (5) @(negedge core_clk);
        check({27'h0, queue_level}, 32'h0);
        reset = 1'b0;
        start_address = from;
        redirect = 1'b1;
        @(negedge core_clk);
        redirect = 1'b0;
        repeat (400) begin
            n = 0;
            if (fetch_request === 1'b1 && first_req === 32'hffffffff) first_req = fetch_address;
            for (int i = 0; i < 3; i++) begin
                if (decode_slots[i].valid === 1'b1 && decode_slots[i].dclass === fast_decode_class) begin
                    got.push_back(decode_slots[i].address);
                    n++;
                end
            end
            most = (n > most) ? n : most;
            if (micro_op.valid === 1'b1) ops++;
            if (micro_op.valid === 1'b1 && micro_op.last === 1'b1) begin
                if (lasts == 0) first_len = ops;
                lasts++;
            end
            @(negedge core_clk);
        end
        check(first_req, from & 32'hfffffff0);
        foreach (exp[i]) check(i < got.size() ? got[i] : 32'hffffffff, 32'(exp[i]));
        check(32'(lasts >= micros), 32'h1);
        if (from == 0) begin
            check(32'(first_len), 32'h2);
            check(32'(most), 32'h3);
        end
        $display("stream from %h delay %0d done", from, d);
    endtask : t_stream
    initial begin
        load_program();
        t_stream(3'h0, 32'h0);
        t_stream(3'h3, 32'h0);
        t_stream(3'h1, 32'h13);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        close_out();
    end
endmodule : decode_slot_selector_tb
